// [src/pixel_output.sv]
// Purpose: Frame sequencing and eight-bank double-rate pixel output.
// Assumes: Link clock is far slower than sys_clk; line buffers hand over groups.
// Notes: Registers sit behind a plain strobe port with one-cycle read data.
`timescale 1ns/100ps
`default_nettype none
module pixel_output
  import rs_pkg::*;
#(
  parameter int SYNC_W = PIX_W,
  parameter logic [SYNC_WORDS*SYNC_W-1:0] SOF_CODES = {14'h3fff, 14'h0000, 14'h0000, 14'h0800},
  parameter logic [SYNC_WORDS*SYNC_W-1:0] LINE_BEGIN_CODES = {14'h3fff, 14'h0000, 14'h0000, 14'h0400},
  parameter logic [SYNC_WORDS*SYNC_W-1:0] LINE_END_CODES = {14'h3fff, 14'h0000, 14'h0000, 14'h0600},
  parameter logic [SYNC_WORDS*SYNC_W-1:0] EOF_CODES = {14'h3fff, 14'h0000, 14'h0000, 14'h0a00}
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  input wire logic frame_trigger,
  input wire logic link_clk,
  input wire logic grp_valid,
  output logic grp_ready,
  input wire pix_group_t grp_data,
  output bank_pins_t [BANKS-1:0] bank_pins_q,
  output logic [DATA_W-1:0] shutter_row_q,
  output logic global_reset_q
);

  initial begin
    if (SYNC_W != PIX_W) $error("sync words must match the pixel width");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and link clock edges
  // ----------------------------------------------------------------------
  logic trig_s1_q, trig_s2_q;
  logic lclk_s1_q, lclk_s2_q, lclk_s3_q;

  // Trigger and link clock are both foreign to sys_clk.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= frame_trigger;
      trig_s2_q <= trig_s1_q;
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  // The falling edge opens each output cycle, the rising edge closes it.
  wire fall_tick = lclk_s3_q & ~lclk_s2_q;
  wire rise_tick = ~lclk_s3_q & lclk_s2_q;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] roi_y_q, roi_h_q, roi_w_q, integ_q;
  logic [DATA_W-1:0] cfg1_q, line_len_q, out_fmt_q, state_q;
  logic [7:0] frames_q;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire wr_roi_y = reg_wr && hit(reg_addr, ROI_Y_ADDR);
  wire wr_roi_h = reg_wr && hit(reg_addr, ROI_H_ADDR);
  wire wr_roi_w = reg_wr && hit(reg_addr, ROI_W_ADDR);
  wire wr_integ = reg_wr && hit(reg_addr, INTEG_ADDR);
  wire wr_cfg1 = reg_wr && hit(reg_addr, CFG1_ADDR);
  wire wr_line = reg_wr && hit(reg_addr, LINE_LEN_ADDR);
  wire wr_fmt = reg_wr && hit(reg_addr, OUT_FMT_ADDR);
  wire wr_state = reg_wr && hit(reg_addr, STATE_ADDR);

  // Writable registers; the frame sequencer only samples them.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      roi_y_q <= ROI_Y_RST;
      roi_h_q <= ROI_H_RST;
      roi_w_q <= ROI_W_RST;
      integ_q <= INTEG_RST;
      cfg1_q <= CFG1_RST;
      line_len_q <= LINE_LEN_RST;
      out_fmt_q <= OUT_FMT_RST;
      state_q <= STATE_RST;
    end else begin
      if (wr_roi_y) roi_y_q <= reg_wdata;
      if (wr_roi_h) roi_h_q <= reg_wdata;
      if (wr_roi_w) roi_w_q <= reg_wdata;
      if (wr_integ) integ_q <= reg_wdata;
      if (wr_cfg1) cfg1_q <= reg_wdata;
      if (wr_line) line_len_q <= reg_wdata;
      if (wr_fmt) out_fmt_q <= reg_wdata;
      if (wr_state) state_q <= reg_wdata;
    end
  end

  typedef enum logic [2:0] {ST_IDLE, ST_INTEG, ST_SOS, ST_PIX, ST_EOS, ST_GAP} seq_state_t;
  seq_state_t st_q;

  wire [DATA_W-1:0] status_w = {frames_q, 6'h00, cfg1_q[MODE_LSB+:2] == MODE_ROLLING,
                                st_q != ST_IDLE};
  wire [DATA_W-1:0] rd_mux =
    hit(reg_addr, ROI_Y_ADDR) ? roi_y_q :
    hit(reg_addr, ROI_H_ADDR) ? roi_h_q :
    hit(reg_addr, ROI_W_ADDR) ? roi_w_q :
    hit(reg_addr, INTEG_ADDR) ? integ_q :
    hit(reg_addr, CFG1_ADDR) ? cfg1_q :
    hit(reg_addr, LINE_LEN_ADDR) ? line_len_q :
    hit(reg_addr, OUT_FMT_ADDR) ? out_fmt_q :
    hit(reg_addr, STATUS_ADDR) ? status_w :
    hit(reg_addr, STATE_ADDR) ? state_q : '0;

  // Read data stand for one cycle only; unmapped addresses read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) reg_rdata_q <= '0;
    else reg_rdata_q <= reg_rd ? rd_mux : '0;
  end

  // ----------------------------------------------------------------------
  // Effective frame settings
  // ----------------------------------------------------------------------
  wire rolling = (cfg1_q[MODE_LSB+:2] == MODE_ROLLING);
  wire start_req = trig_s2_q || (state_q == CONT_CAPTURE_VAL);
  wire [DATA_W-1:0] row_start = {roi_y_q[DATA_W-1:1], 1'b0};
  wire [DATA_W-1:0] pairs_raw = {1'b0, roi_h_q[DATA_W-1:1]};
  wire [DATA_W-1:0] pairs = (pairs_raw == '0) ? 16'h0001 : pairs_raw;
  wire [DATA_W-1:0] groups_raw = {2'h0, roi_w_q[DATA_W-1:2]};
  wire [DATA_W-1:0] groups = (groups_raw == '0) ? 16'h0001 : groups_raw;
  wire [1:0] fmt_banks = out_fmt_q[BANKSEL_LSB+:2];
  wire [1:0] bank_code = (fmt_banks == 2'h3) ? 2'h2 : fmt_banks;
  wire [2:0] per_side = 3'(3'h4 >> bank_code);
  wire [1:0] phase_last = 2'((3'h1 << bank_code) - 3'h1);
  wire [2:0] half = HALF_BASE + {1'b0, out_fmt_q[DEPTH_LSB+:2]};
  wire [PIX_W-1:0] depth_mask = 14'(14'h3fff >> (4'he - {half, 1'b0}));

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] lt_q, int_cnt_q, line_idx_q, grp_cnt_q, reset_left_q;
  logic [1:0] sync_cnt_q, phase_q;
  logic buf_valid;
  pix_group_t buf_data;
  wire buf_take;

  // Two groups of slack let the line buffers run ahead while a bank sends sync words.
  pair_buffer #(
    .W($bits(pix_group_t)),
    .DEPTH(2)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(grp_valid),
    .in_ready(grp_ready),
    .in_data(grp_data),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );

  // One line time covers an even and an odd row read side by side.
  wire line_tick = rise_tick && (lt_q >= line_len_q - 16'h0001) &&
                   (st_q == ST_INTEG || st_q == ST_GAP);
  wire last_line = (line_idx_q == pairs - 16'h0001);
  wire last_group = (grp_cnt_q == groups - 16'h0001) && (phase_q == phase_last);
  wire pix_take = rise_tick && (st_q == ST_PIX) && buf_valid;
  wire shutter_adv = line_tick && (reset_left_q != '0);
  assign buf_take = pix_take && (phase_q == phase_last);

  // Sequencer steps once per output cycle; a starved line simply waits.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      lt_q <= '0;
      int_cnt_q <= '0;
      line_idx_q <= '0;
      grp_cnt_q <= '0;
      sync_cnt_q <= '0;
      phase_q <= '0;
    end else if (rise_tick) begin
      lt_q <= line_tick ? '0 : 16'(lt_q + 16'h0001);
      case (st_q)
        ST_IDLE: begin
          lt_q <= '0;
          int_cnt_q <= '0;
          line_idx_q <= '0;
          if (start_req) st_q <= ST_INTEG;
        end
        ST_INTEG: begin
          if (line_tick) begin
            int_cnt_q <= 16'(int_cnt_q + 16'h0001);
            if (int_cnt_q + 16'h0001 >= integ_q) st_q <= ST_SOS;
          end
        end
        ST_SOS: begin
          sync_cnt_q <= 2'(sync_cnt_q + 2'h1);
          if (sync_cnt_q == 2'h3) begin
            st_q <= ST_PIX;
            grp_cnt_q <= '0;
            phase_q <= '0;
          end
        end
        ST_PIX: begin
          if (buf_valid) begin
            phase_q <= (phase_q == phase_last) ? 2'h0 : 2'(phase_q + 2'h1);
            if (phase_q == phase_last) grp_cnt_q <= 16'(grp_cnt_q + 16'h0001);
            if (last_group) st_q <= ST_EOS;
          end
        end
        ST_EOS: begin
          sync_cnt_q <= 2'(sync_cnt_q + 2'h1);
          if (sync_cnt_q == 2'h3) st_q <= ST_GAP;
        end
        ST_GAP: begin
          if (line_tick && last_line) begin
            line_idx_q <= '0;
            int_cnt_q <= '0;
            st_q <= start_req ? ST_INTEG : ST_IDLE;
          end else if (line_tick) begin
            line_idx_q <= 16'(line_idx_q + 16'h0001);
            st_q <= ST_SOS;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Row reset pointer: rolling mode walks it one row pair per line time, so
  // every pair integrates exactly as long; global mode resets all at once.
  wire frame_begin = rise_tick && start_req &&
                     (st_q == ST_IDLE || (st_q == ST_GAP && line_tick && last_line));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shutter_row_q <= '0;
      reset_left_q <= '0;
      global_reset_q <= 1'b0;
      frames_q <= '0;
    end else begin
      global_reset_q <= frame_begin && !rolling;
      if (frame_begin) begin
        shutter_row_q <= row_start;
        reset_left_q <= rolling ? 16'(pairs - 16'h0001) : '0;
        frames_q <= 8'(frames_q + 8'h01);
      end else if (shutter_adv) begin
        shutter_row_q <= 16'(shutter_row_q + 16'h0002);
        reset_left_q <= 16'(reset_left_q - 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bank words and serializers
  // ----------------------------------------------------------------------
  wire [SYNC_WORDS*SYNC_W-1:0] head_codes = (line_idx_q == '0) ? SOF_CODES : LINE_BEGIN_CODES;
  wire [SYNC_WORDS*SYNC_W-1:0] tail_codes = last_line ? EOF_CODES : LINE_END_CODES;
  wire [SYNC_W-1:0] head_word = head_codes[sync_cnt_q*SYNC_W +: SYNC_W];
  wire [SYNC_W-1:0] tail_word = tail_codes[sync_cnt_q*SYNC_W +: SYNC_W];
  logic [BANKS-1:0][PIX_W-1:0] word_q;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      localparam logic [2:0] POS = 3'(b / 2);
      wire active = (POS < per_side);
      wire [2:0] pix_idx = 3'(phase_q * per_side + POS);
      wire [PIX_W-1:0] pix = (b % 2 == 1) ? buf_data.odd[pix_idx[1:0]] :
                             buf_data.even[pix_idx[1:0]];
      wire [PIX_W-1:0] next_word =
        (st_q == ST_SOS) ? head_word :
        (st_q == ST_EOS) ? tail_word :
        (st_q == ST_PIX && buf_valid) ? pix : '0;

      // The word is chosen at the rising edge for the next output cycle.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) word_q[b] <= '0;
        else if (rise_tick) word_q[b] <= next_word & depth_mask;
      end

      bank_serializer u_ser (
        .sys_clk(sys_clk),
        .rst(rst),
        .fall_tick(fall_tick),
        .rise_tick(rise_tick),
        .link_level(lclk_s2_q),
        .active(active),
        .half(half),
        .word(word_q[b]),
        .pins_q(bank_pins_q[b])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_capture_start: assert property (@(posedge sys_clk) disable iff (rst)
    (rise_tick && st_q == ST_IDLE && start_req) |=> st_q == ST_INTEG)
    else $error("capture request did not start integration");

  chk_repeat_frame: assert property (@(posedge sys_clk) disable iff (rst)
    (rise_tick && st_q == ST_GAP && line_tick && last_line && start_req)
      |=> st_q == ST_INTEG ##1 frames_q == $past(frames_q, 2) + 8'h01)
    else $error("held trigger did not give a further frame");

  chk_sync_lead: assert property (@(posedge sys_clk) disable iff (rst)
    (rise_tick && st_q == ST_SOS && sync_cnt_q == 2'h3) |=> st_q == ST_PIX)
    else $error("pixels did not follow four start words");

  chk_sync_tail: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(st_q == ST_GAP)) |-> $past(st_q) == ST_EOS && $past(sync_cnt_q) == 2'h3)
    else $error("line ended without four end words");

  chk_even_rows: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q != ST_IDLE) |-> shutter_row_q[0] == 1'b0 && !pairs[15])
    else $error("region start row is odd");

  chk_rolling_stagger: assert property (@(posedge sys_clk) disable iff (rst)
    (shutter_adv && !frame_begin) |=> shutter_row_q == $past(shutter_row_q) + 16'h0002)
    else $error("rolling reset pointer did not step one row pair");

  chk_global_reset: assert property (@(posedge sys_clk) disable iff (rst)
    global_reset_q |-> $past(frame_begin) && $past(!rolling))
    else $error("global reset outside a global-mode frame start");

  chk_pixel_order: assert property (@(posedge sys_clk) disable iff (rst)
    (pix_take && bank_code == 2'h0) |=> word_q[2] == ($past(buf_data.even[1]) & depth_mask)
      && word_q[7] == ($past(buf_data.odd[3]) & depth_mask))
    else $error("pixel landed on the wrong bank");

endmodule
`default_nettype wire

// [src/rs_pkg.sv]
// Purpose: Shared constants and carrier types for the pixel output path.
// Assumes: Registers are 16 bits wide and reached at their 16-bit addresses.
// Notes: Every offset, field position, reset value and count is named here once.
package rs_pkg;

  // ----------------------------------------------------------------------
  // Geometry of the output path
  // ----------------------------------------------------------------------
  localparam int PIX_W = 14;
  localparam int LANES = 7;
  localparam int BANKS = 8;
  localparam int ROW_BANKS = 4;
  localparam int SYNC_WORDS = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ROI_Y_ADDR = 16'h0001;
  localparam logic [ADDR_W-1:0] ROI_H_ADDR = 16'h0009;
  localparam logic [ADDR_W-1:0] ROI_W_ADDR = 16'h0019;
  localparam logic [ADDR_W-1:0] INTEG_ADDR = 16'h0091;
  localparam logic [ADDR_W-1:0] CFG1_ADDR = 16'h01d1;
  localparam logic [ADDR_W-1:0] LINE_LEN_ADDR = 16'h0201;
  localparam logic [ADDR_W-1:0] OUT_FMT_ADDR = 16'h3001;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h3009;
  localparam logic [ADDR_W-1:0] STATE_ADDR = 16'h4019;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ROI_Y_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ROI_H_RST = 16'h0860;
  localparam logic [DATA_W-1:0] ROI_W_RST = 16'h0b20;
  localparam logic [DATA_W-1:0] INTEG_RST = 16'h0d66;
  localparam logic [DATA_W-1:0] CFG1_RST = 16'hfc10;
  localparam logic [DATA_W-1:0] LINE_LEN_RST = 16'h0578;
  localparam logic [DATA_W-1:0] OUT_FMT_RST = 16'h0001;
  localparam logic [DATA_W-1:0] STATE_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // Fields and encodings
  // ----------------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_ROLLING = 2'h1;
  localparam logic [DATA_W-1:0] CONT_CAPTURE_VAL = 16'h0003;
  localparam int DEPTH_LSB = 0;
  localparam int BANKSEL_LSB = 2;
  localparam logic [2:0] HALF_BASE = 3'h4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ROLL_BIT = 1;
  localparam int STAT_FRAMES_LSB = 8;

  // Eight pixels handed over by the line buffers per group; one group per output cycle with eight banks.
  typedef struct packed {
    logic [ROW_BANKS-1:0][PIX_W-1:0] odd;
    logic [ROW_BANKS-1:0][PIX_W-1:0] even;
  } pix_group_t;

  // Pins of one output bank, each with its own output enable.
  typedef struct packed {
    logic clk;
    logic clk_oe;
    logic [LANES-1:0] lane;
    logic [LANES-1:0] oe;
  } bank_pins_t;

endpackage

// [src/pair_buffer.sv]
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Writer and reader share sys_clk.
// Notes: Full and empty are exact, so a stalled reader holds back the writer.
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  initial begin
    if (DEPTH != 2) $error("pair_buffer supports two entries only");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // Pointers and occupancy.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end

  // Storage carries no reset, only the pointers and the count need one.
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end

  chk_buffer_full: assert property (@(posedge sys_clk) disable iff (rst)
    (count_q == 2'h2 && !pop) |=> !in_ready)
    else $error("buffer accepted a word while full");

endmodule
`default_nettype wire

// [src/bank_serializer.sv]
// Purpose: One output bank: half-word lanes, lane enables and forwarded clock.
// Assumes: Edge pulses come from the synchronised link clock.
// Notes: Upper half-word goes on the falling edge, lower half on the next rise.
`timescale 1ns/100ps
`default_nettype none
module bank_serializer
  import rs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fall_tick,
  input wire logic rise_tick,
  input wire logic link_level,
  input wire logic active,
  input wire logic [2:0] half,
  input wire logic [PIX_W-1:0] word,
  output bank_pins_t pins_q
);

  logic [LANES-1:0] low_q;
  wire [LANES-1:0] en_mask = 7'(7'h7f >> (3'h7 - half));
  wire [PIX_W-1:0] upper_w = word >> half;
  wire [LANES-1:0] upper = upper_w[LANES-1:0] & en_mask;

  // Lanes beyond the half-word stay released and quiet.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_q <= '0;
      low_q <= '0;
    end else begin
      pins_q.oe <= active ? en_mask : '0;
      pins_q.clk_oe <= active;
      pins_q.clk <= active & link_level;
      if (fall_tick) begin
        pins_q.lane <= active ? upper : '0;
        low_q <= word[LANES-1:0] & en_mask;
      end else if (rise_tick) begin
        pins_q.lane <= active ? low_q : '0;
      end
    end
  end

  chk_falling_upper: assert property (@(posedge sys_clk) disable iff (rst)
    (fall_tick && active) |=> pins_q.lane == $past(upper))
    else $error("falling edge did not carry the upper half-word");

  chk_lane_count: assert property (@(posedge sys_clk) disable iff (rst)
    active |=> $countones(pins_q.oe) == int'($past(half)))
    else $error("enabled lane count differs from half the bit depth");

endmodule
`default_nettype wire

// [verif/lane_receiver.sv]
// Purpose: Receiver model for one output bank.
// Assumes: Bank pins are sampled on sys_clk, far faster than the bank clock.
// Notes: A rise seen before any fall is dropped, so words never start mid-pair.
`timescale 1ns/100ps
`default_nettype none
module lane_receiver
  import rs_pkg::*;
#(
  parameter int HALF = 7
) (
  input wire logic sys_clk,
  input wire bank_pins_t pins,
  output logic [PIX_W-1:0] word_q,
  output logic word_valid_q
);
  logic clk_prev_q = 1'b0;
  logic have_hi_q = 1'b0;
  logic [LANES-1:0] hi_q;
  // Upper half on the falling edge, lower half on the following rise.
  always_ff @(posedge sys_clk) begin
    clk_prev_q <= pins.clk;
    word_valid_q <= 1'b0;
    if (clk_prev_q && !pins.clk) begin
      hi_q <= pins.lane;
      have_hi_q <= 1'b1;
    end else if (!clk_prev_q && pins.clk && have_hi_q) begin
      word_q <= PIX_W'((PIX_W'(hi_q) << HALF) | PIX_W'(pins.lane));
      word_valid_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench for the pixel output path.
// Assumes: 14-bit depth and eight banks during the streaming test.
// Notes: Banks 0 and 1 are decoded; the others share the same logic.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rs_pkg::*;
  localparam logic [4*PIX_W-1:0] SOF = {14'h3fff, 14'h0000, 14'h0000, 14'h0a1b};
  localparam logic [4*PIX_W-1:0] EOF = {14'h3fff, 14'h0000, 14'h0000, 14'h0c2d};
  localparam logic [4*PIX_W-1:0] LBEG = {14'h3fff, 14'h0000, 14'h0000, 14'h0b4e};
  localparam logic [4*PIX_W-1:0] LEND = {14'h3fff, 14'h0000, 14'h0000, 14'h0d5f};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic frame_trigger = 1'b0;
  logic grp_valid = 1'b0;
  pix_group_t grp_data = '0;
  logic [DATA_W-1:0] reg_rdata_q;
  logic grp_ready;
  bank_pins_t [BANKS-1:0] bank_pins_q;
  logic [DATA_W-1:0] shutter_row_q;
  logic global_reset_q;
  int n_gr = 0;
  logic [PIX_W-1:0] rx_word [2];
  logic [1:0] rx_valid;
  logic [PIX_W:0] exp_q [2][$];
  logic [DATA_W-1:0] rd_q [$];
  int failures = 0;
  int n_checks = 0;
  int taken = 0;
  int cycles = 0;
  // ----------------------------------------------------------------------
  // Clocks, design and receivers
  // ----------------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  always #62.5 link_clk = ~link_clk;
  pixel_output #(.SOF_CODES(SOF), .LINE_BEGIN_CODES(LBEG), .LINE_END_CODES(LEND),
    .EOF_CODES(EOF)) dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .frame_trigger(frame_trigger), .link_clk(link_clk),
    .grp_valid(grp_valid), .grp_ready(grp_ready), .grp_data(grp_data),
    .bank_pins_q(bank_pins_q), .shutter_row_q(shutter_row_q), .global_reset_q(global_reset_q));
  for (genvar b = 0; b < 2; b++) begin : rx
    lane_receiver #(.HALF(7)) u_rx (.sys_clk(sys_clk), .pins(bank_pins_q[b]),
      .word_q(rx_word[b]), .word_valid_q(rx_valid[b]));
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Each access leaves an idle cycle so no strobe is assigned twice at one edge.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // The low word goes first; a head word is marked, as idle zero words may precede it.
  task automatic push_sync(input logic [4*PIX_W-1:0] c, input logic head);
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 4; i++) exp_q[b].push_back({1'(head && i == 0), c[i*PIX_W +: PIX_W]});
  endtask
  // ----------------------------------------------------------------------
  // Watchers: read data one cycle after the strobe, pixel source and lanes
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(posedge sys_clk) if (global_reset_q === 1'b1) n_gr++;
  always @(negedge sys_clk) if (rd_seen) check(reg_rdata_q, rd_q.pop_front());
  always @(posedge sys_clk) begin
    cycles++;
    if (grp_valid && grp_ready) begin
      exp_q[0].push_back({1'b0, grp_data.even[0]});
      exp_q[1].push_back({1'b0, grp_data.odd[0]});
      grp_data <= 112'({$urandom, $urandom, $urandom, $urandom});
      taken++;
      if (taken == 2) begin
        push_sync(LEND, 1'b0);
        push_sync(LBEG, 1'b1);
      end
      if (taken == 4) begin
        grp_valid <= 1'b0;
        push_sync(EOF, 1'b0);
      end
    end
    // Idle zero words before a head word are skipped; every other word is compared while expectations remain.
    for (int b = 0; b < 2; b++) if (rx_valid[b] && exp_q[b].size() > 0) begin
      if (!(exp_q[b][0][PIX_W] && rx_word[b] === '0)) begin
        check(16'(rx_word[b]), 16'(exp_q[b][0][PIX_W-1:0]));
        void'(exp_q[b].pop_front());
      end
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h223d2c0c));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(CFG1_ADDR, CFG1_RST);
    rd(OUT_FMT_ADDR, OUT_FMT_RST);
    rd(16'h0011, 16'h0000);
    check({9'h000, bank_pins_q[7].oe}, 16'h001f);
    wr(CFG1_ADDR, 16'hfc11);
    rd(CFG1_ADDR, 16'hfc11);
    wr(OUT_FMT_ADDR, 16'h0003);
    wr(ROI_Y_ADDR, 16'h0001);
    wr(ROI_H_ADDR, 16'h0005);
    wr(ROI_W_ADDR, 16'h0008);
    wr(INTEG_ADDR, 16'h0001);
    wr(LINE_LEN_ADDR, 16'h0020);
    check({9'h000, bank_pins_q[7].oe}, 16'h007f);
    grp_data <= 112'({$urandom, $urandom, $urandom, $urandom});
    grp_valid <= 1'b1;
    push_sync(SOF, 1'b1);
    wr(STATE_ADDR, CONT_CAPTURE_VAL);
    rd(STATE_ADDR, CONT_CAPTURE_VAL);
    // A run that never drains its expectations ends here as a failure.
    while ((taken < 4 || exp_q[0].size() > 0 || exp_q[1].size() > 0) && cycles < 20000)
      @(posedge sys_clk);
    if (cycles >= 20000) failures++;
    check(shutter_row_q, 16'h0002);
    repeat (1200) @(posedge sys_clk);
    rd(STATUS_ADDR, 16'h0203);
    check(16'(n_gr), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
